/* rtl/mtsl_params.svh */
// Constants of the motor terminal status LED block: offsets, fields, times.
// Assumes a 32-bit classic Wishbone slave at 250 MHz.
`ifndef MTSL_PARAMS_SVH
`define MTSL_PARAMS_SVH

// Register byte offsets
`define MTSL_ADR_CTRL     8'h00
`define MTSL_ADR_LEDS     8'h04
`define MTSL_ADR_IRQ_STAT 8'h08
`define MTSL_ADR_IRQ_MASK 8'h0C

// Control register fields
`define MTSL_CTRL_STATE_LSB 0
`define MTSL_CTRL_EN_A      3
`define MTSL_CTRL_EN_B      4
`define MTSL_CTRL_READY     5
`define MTSL_CTRL_LATCH_A   6
`define MTSL_CTRL_LATCH_B   7
`define MTSL_CTRL_RST       5'h00

// Slave state codes as written by software
`define MTSL_CODE_INIT   3'h0
`define MTSL_CODE_PREOP  3'h1
`define MTSL_CODE_SAFEOP 3'h2
`define MTSL_CODE_OP     3'h3
`define MTSL_CODE_BOOT   3'h4

// Interrupt status bits
`define MTSL_IRQ_WARN    0
`define MTSL_IRQ_ERR_A   1
`define MTSL_IRQ_ERR_B   2
`define MTSL_IRQ_LATCH_A 3
`define MTSL_IRQ_LATCH_B 4
`define MTSL_IRQ_RST     5'h00

// Blink timing: base tick and frame of ticks
`define MTSL_CLK_MHZ     64'h0FA
`define MTSL_TICK_NS     64'h2FAF080
`define MTSL_FRAME_LAST  5'h17
`define MTSL_SFLASH_LEN  5'h04

`endif

/* rtl/mtsl_pkg.sv */
// Types of the motor terminal status LED block.
// Assumes nothing beyond the params header for its users.
package mtsl_pkg;

    // Fieldbus slave state, one-hot
    typedef enum logic [4:0] {
        MTSL_INIT   = 5'h01,
        MTSL_PREOP  = 5'h02,
        MTSL_SAFEOP = 5'h04,
        MTSL_OP     = 5'h08,
        MTSL_BOOT   = 5'h10
    } mtsl_esm_t;

endpackage : mtsl_pkg

/* rtl/mtsl_top.sv */
// Front-panel status LED logic for a two-channel DC motor terminal.
// Assumes one 250 MHz clock, sync reset, classic Wishbone software access,
// and asynchronous pin inputs for encoders, digital inputs and faults.
//
// Operation
// - Run LED dark while the slave state is INIT.
// - Run LED flashes regularly while in PREOP.
// - Run LED gives a single flash while in SAFEOP.
// - In SAFEOP all outputs, both motor stages, stay in safe state.
// - Run LED steadily lit while in OP.
// - Run LED flickers fast while in BOOTSTRAP.
// - Enable A LED lit when motor A enabled and terminal ready.
// - Enable B LED lit when motor B enabled and terminal ready.
// - Warning LED lit on a warning condition, dark otherwise.
// - Error A LED lit on an output stage A fault.
// - Error B LED lit on an output stage B fault.
// - Four encoder echo LEDs follow their own encoder track inputs.
// - Two digital input LEDs follow their own digital inputs.
// - Digital input 1 and 2 may trigger position latch A and B.
//
// Register access over Wishbone and the register offsets were decided locally.
`include "mtsl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mtsl_top #(
    parameter int unsigned TICK_CYC =
        32'((`MTSL_TICK_NS * `MTSL_CLK_MHZ) / 64'h3E8)
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Pin inputs, asynchronous
    input  wire logic [3:0]  enc_i,
    input  wire logic [1:0]  din_i,
    input  wire logic        warn_i,
    input  wire logic        fault_a_i,
    input  wire logic        fault_b_i,
    // LEDs
    output logic             led_run,
    output logic             led_en_a,
    output logic             led_en_b,
    output logic             led_warn,
    output logic             led_err_a,
    output logic             led_err_b,
    output logic      [3:0]  led_enc,
    output logic      [1:0]  led_din,
    // Motor stage enables and latch triggers
    output logic             motor_a_en,
    output logic             motor_b_en,
    output logic             latch_a,
    output logic             latch_b,
    // Interrupt
    output logic             irq
);

    // Map a software state code to the one-hot state; illegal keeps old
    function automatic mtsl_pkg::mtsl_esm_t code_to_esm(
        input logic [2:0]           code,
        input mtsl_pkg::mtsl_esm_t  old
    );
        mtsl_pkg::mtsl_esm_t r;
        r = old;
        if (code == `MTSL_CODE_INIT) begin
            r = mtsl_pkg::MTSL_INIT;
        end else if (code == `MTSL_CODE_PREOP) begin
            r = mtsl_pkg::MTSL_PREOP;
        end else if (code == `MTSL_CODE_SAFEOP) begin
            r = mtsl_pkg::MTSL_SAFEOP;
        end else if (code == `MTSL_CODE_OP) begin
            r = mtsl_pkg::MTSL_OP;
        end else if (code == `MTSL_CODE_BOOT) begin
            r = mtsl_pkg::MTSL_BOOT;
        end
        return r;
    endfunction : code_to_esm

    // Map the one-hot state back to its software code
    function automatic logic [2:0] esm_to_code(
        input mtsl_pkg::mtsl_esm_t s
    );
        logic [2:0] c;
        c = `MTSL_CODE_INIT;
        unique case (s)
            mtsl_pkg::MTSL_INIT:   c = `MTSL_CODE_INIT;
            mtsl_pkg::MTSL_PREOP:  c = `MTSL_CODE_PREOP;
            mtsl_pkg::MTSL_SAFEOP: c = `MTSL_CODE_SAFEOP;
            mtsl_pkg::MTSL_OP:     c = `MTSL_CODE_OP;
            mtsl_pkg::MTSL_BOOT:   c = `MTSL_CODE_BOOT;
        endcase
        return c;
    endfunction : esm_to_code

    localparam int PIN_W = 9;

    mtsl_pkg::mtsl_esm_t state_q;
    logic [4:0]       ctrl_q;
    logic [4:0]       stat_q;
    logic [4:0]       mask_q;
    logic             ack_q;
    logic [31:0]      dat_q;
    logic [23:0]      tick_cnt_q;
    logic [4:0]       phase_q;
    logic [PIN_W-1:0] sync1_q;
    logic [PIN_W-1:0] sync2_q;
    logic [PIN_W-1:0] prev_q;
    logic             run_q;
    logic             en_a_q;
    logic             en_b_q;
    logic             warn_q;
    logic             err_a_q;
    logic             err_b_q;
    logic [3:0]       enc_q;
    logic [1:0]       din_q;
    logic             mot_a_q;
    logic             mot_b_q;
    logic             lat_a_q;
    logic             lat_b_q;
    logic             irq_q;

    // Bus decode; writes land on the edge that sees ack high
    wire        req      = wb_cyc_i & wb_stb_i;
    wire        wr_go    = req & wb_we_i & ack_q & wb_sel_i[0];
    wire        hit_ctrl = wb_adr_i == `MTSL_ADR_CTRL;
    wire        hit_leds = wb_adr_i == `MTSL_ADR_LEDS;
    wire        hit_stat = wb_adr_i == `MTSL_ADR_IRQ_STAT;
    wire        hit_mask = wb_adr_i == `MTSL_ADR_IRQ_MASK;
    wire        wr_ctrl  = wr_go & hit_ctrl;
    wire        wr_stat  = wr_go & hit_stat;
    wire        wr_mask  = wr_go & hit_mask;

    // Pattern ticks and synchronised pins
    wire        tick     = tick_cnt_q == 24'(TICK_CYC - 1);
    wire [3:0]  enc_s    = sync2_q[3:0];
    wire [1:0]  din_s    = sync2_q[5:4];
    wire        warn_s   = sync2_q[6];
    wire        flt_a_s  = sync2_q[7];
    wire        flt_b_s  = sync2_q[8];
    wire [PIN_W-1:0] rise = sync2_q & ~prev_q;

    // Control fields
    // Control flops hold data bits 7:3, so field N sits at ctrl_q[N-3]
    wire        ready    = ctrl_q[`MTSL_CTRL_READY - 3];
    wire        en_a     = ctrl_q[0];
    wire        en_b     = ctrl_q[1];
    wire        lmode_a  = ctrl_q[3];
    wire        lmode_b  = ctrl_q[4];
    wire        is_op    = state_q == mtsl_pkg::MTSL_OP;

    // Latch triggers fire on a rising digital input edge
    wire        trig_a   = rise[4] & lmode_a;
    wire        trig_b   = rise[5] & lmode_b;

    // Sticky events; a new event beats a clear in the same cycle
    wire [4:0]  events   = {trig_b, trig_a, rise[8], rise[7], rise[6]};
    wire [4:0]  stat_clr = wr_stat ? wb_dat_i[4:0] : 5'h00;
    wire [4:0]  stat_d   = (stat_q & ~stat_clr) | events;

    wire [31:0] led_img  = {19'h00000, irq_q, din_q, enc_q, err_b_q,
                            err_a_q, warn_q, en_b_q, en_a_q, run_q};
    wire [31:0] rd_data  =
        hit_ctrl ? {24'h000000, ctrl_q, esm_to_code(state_q)} :
        hit_leds ? led_img :
        hit_stat ? {27'h0000000, stat_q} :
        hit_mask ? {27'h0000000, mask_q} : 32'h00000000;

    // Run LED pattern per state
    logic run_d;
    always_comb begin
        run_d = 1'b0;
        unique case (state_q)
            mtsl_pkg::MTSL_INIT:   run_d = 1'b0;
            mtsl_pkg::MTSL_PREOP:  run_d = phase_q[2];
            mtsl_pkg::MTSL_SAFEOP: run_d =
                phase_q < `MTSL_SFLASH_LEN;
            mtsl_pkg::MTSL_OP:     run_d = 1'b1;
            mtsl_pkg::MTSL_BOOT:   run_d = phase_q[0];
        endcase
    end

    // Bus answers one cycle after the request, then drops
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req & ~ack_q;
            dat_q <= rd_data;
        end
    end

    // Software registers; reset leaves the state at INIT
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= mtsl_pkg::MTSL_INIT;
            ctrl_q  <= `MTSL_CTRL_RST;
            mask_q  <= `MTSL_IRQ_RST;
            stat_q  <= `MTSL_IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                state_q <= code_to_esm(wb_dat_i[2:0], state_q);
                ctrl_q  <= wb_dat_i[7:3];
            end
            if (wr_mask) begin
                mask_q <= wb_dat_i[4:0];
            end
            stat_q <= stat_d;
        end
    end

    // Blink base: one tick per 50 ms, a 24-tick frame of 1.2 s
    always_ff @(posedge clock) begin
        if (rst) begin
            tick_cnt_q <= 24'h000000;
            phase_q    <= 5'h00;
        end else begin
            tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
            if (tick) begin
                phase_q <= (phase_q == `MTSL_FRAME_LAST) ?
                           5'h00 : phase_q + 5'h01;
            end
        end
    end

    // Two-stage synchroniser; edge history reads the second stage only
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= {fault_b_i, fault_a_i, warn_i, din_i, enc_i};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // LED and output flops
    always_ff @(posedge clock) begin
        if (rst) begin
            {run_q, en_a_q, en_b_q, warn_q, err_a_q, err_b_q} <= 6'h00;
            enc_q <= 4'h0;
            din_q <= 2'h0;
            {mot_a_q, mot_b_q, lat_a_q, lat_b_q, irq_q} <= 5'h00;
        end else begin
            run_q   <= run_d;
            en_a_q  <= en_a & ready;
            en_b_q  <= en_b & ready;
            warn_q  <= warn_s;
            err_a_q <= flt_a_s;
            err_b_q <= flt_b_s;
            enc_q   <= enc_s;
            din_q   <= din_s;
            // Stages only drive in OP, so SAFEOP is safe
            mot_a_q <= en_a & ready & is_op;
            mot_b_q <= en_b & ready & is_op;
            lat_a_q <= trig_a;
            lat_b_q <= trig_b;
            irq_q   <= |(stat_q & mask_q);
        end
    end

    assign wb_ack_o   = ack_q;
    assign wb_dat_o   = dat_q;
    assign led_run    = run_q;
    assign led_en_a   = en_a_q;
    assign led_en_b   = en_b_q;
    assign led_warn   = warn_q;
    assign led_err_a  = err_a_q;
    assign led_err_b  = err_b_q;
    assign led_enc    = enc_q;
    assign led_din    = din_q;
    assign motor_a_en = mot_a_q;
    assign motor_b_en = mot_b_q;
    assign latch_a    = lat_a_q;
    assign latch_b    = lat_b_q;
    assign irq        = irq_q;

    // Checks on the LEDs, motor stage enables, latch pulses and reset state
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_warn_hi;  warn_i[*4];    endsequence
    sequence s_flta_hi;  fault_a_i[*4]; endsequence
    sequence s_fltb_hi;  fault_b_i[*4]; endsequence
    sequence s_enc0_hi;  enc_i[0][*4];  endsequence
    sequence s_din1_lo;  !din_i[1][*4]; endsequence

    property p_init_dark;
        state_q == mtsl_pkg::MTSL_INIT |=> !led_run;
    endproperty
    a_init_dark: assert property (p_init_dark)
        else $error("run led lit in init");

    property p_flash;
        state_q == mtsl_pkg::MTSL_PREOP |=> led_run == $past(phase_q[2]);
    endproperty
    a_flash: assert property (p_flash)
        else $error("run led not flashing in preop");

    property p_sflash;
        state_q == mtsl_pkg::MTSL_SAFEOP |=>
            led_run == ($past(phase_q) < 5'h04);
    endproperty
    a_sflash: assert property (p_sflash)
        else $error("run led not single flash in safeop");

    property p_safe;
        state_q == mtsl_pkg::MTSL_SAFEOP |=> !motor_a_en && !motor_b_en;
    endproperty
    a_safe: assert property (p_safe)
        else $error("motor stage enabled in safeop");

    property p_op_on;
        (state_q == mtsl_pkg::MTSL_OP) [*2] |-> led_run;
    endproperty
    a_op_on: assert property (p_op_on)
        else $error("run led dark in op");

    property p_flicker;
        state_q == mtsl_pkg::MTSL_BOOT |=> led_run == $past(phase_q[0]);
    endproperty
    a_flicker: assert property (p_flicker)
        else $error("run led not flickering in boot");

    property p_en_a;
        $rose(ctrl_q[0] & ctrl_q[2]) |=> led_en_a;
    endproperty
    a_en_a: assert property (p_en_a)
        else $error("enable a led late");

    property p_en_b;
        $fell(ctrl_q[1] & ctrl_q[2]) |=> !led_en_b;
    endproperty
    a_en_b: assert property (p_en_b)
        else $error("enable b led stays lit");

    property p_warn;
        s_warn_hi |-> led_warn;
    endproperty
    a_warn: assert property (p_warn)
        else $error("warning led dark on warning");

    property p_err_a;
        s_flta_hi |-> led_err_a;
    endproperty
    a_err_a: assert property (p_err_a)
        else $error("error a led dark on fault");

    property p_err_b;
        s_fltb_hi |-> led_err_b;
    endproperty
    a_err_b: assert property (p_err_b)
        else $error("error b led dark on fault");

    property p_enc;
        s_enc0_hi |-> led_enc[0];
    endproperty
    a_enc: assert property (p_enc)
        else $error("encoder led dark on signal");

    property p_din;
        s_din1_lo |-> !led_din[1];
    endproperty
    a_din: assert property (p_din)
        else $error("input led lit without signal");

    property p_latch;
        latch_a |-> $past(lmode_a) ##1 !latch_a;
    endproperty
    a_latch: assert property (p_latch)
        else $error("latch pulse wrong");

    property p_reset_init;
        disable iff (1'b0) rst |=> state_q == mtsl_pkg::MTSL_INIT;
    endproperty
    a_reset_init: assert property (p_reset_init)
        else $error("state not init after reset");

    property p_sync;
        led_enc[1] == $past(enc_i[1], 3);
    endproperty
    a_sync: assert property (p_sync)
        else $error("encoder echo not three cycles");

endmodule : mtsl_top

`default_nettype wire

/* tb/motor_terminal_status_leds_tb.sv */
// Self-checking bench of the status LED block with a pin model.
// Assumes a short blink tick (4 cycles) so a 24-tick frame is 96 cycles.
`include "mtsl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module motor_terminal_status_leds_tb;
    localparam int FRAME = 96;
    logic clock, rst, cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [5:0] req_io;
    logic [2:0] req_flt;
    logic [3:0] enc, led_enc;
    logic [1:0] din, led_din;
    logic warn, fa, fb, run, en_a, en_b, lw, le_a, le_b, m_a, m_b, lt_a, lt_b;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    mtsl_top #(.TICK_CYC(4)) i_dut (.clock(clock), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .enc_i(enc), .din_i(din), .warn_i(warn), .fault_a_i(fa),
        .fault_b_i(fb), .led_run(run), .led_en_a(en_a), .led_en_b(en_b),
        .led_warn(lw), .led_err_a(le_a), .led_err_b(le_b),
        .led_enc(led_enc), .led_din(led_din), .motor_a_en(m_a),
        .motor_b_en(m_b), .latch_a(lt_a), .latch_b(lt_b), .irq(irq));

    mtsl_pin_model i_pins (.clock(clock), .rst(rst), .req_io(req_io),
        .req_flt(req_flt), .enc_o(enc), .din_o(din), .warn_o(warn),
        .fault_a_o(fa), .fault_b_o(fb));

    // Free-running 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Hang guard, well above the expected run time
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc_wait

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 40);
        r = rdat;
        if (n >= 40) chk("ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask : wb

    // Run LED over one full frame: lit cycles and rising edges
    task automatic t_run(input logic [2:0] code, input int on_x,
                         input int rise_x);
        int on, rs;
        logic prev;
        on = 0;
        rs = 0;
        wb(1'b1, `MTSL_ADR_CTRL, {29'h7, code}, q);
        cyc_wait(4);
        prev = run;
        repeat (FRAME) begin
            @(posedge clock);
            on += int'(run === 1'b1);
            rs += int'(prev === 1'b0 && run === 1'b1);
            prev = run;
        end
        chk("run_on", on_x, on);
        chk("run_rises", rise_x, rs);
        chk("motor_a", code == `MTSL_CODE_OP, m_a);
        chk("motor_b", code == `MTSL_CODE_OP, m_b);
        wb(1'b0, `MTSL_ADR_CTRL, 32'h0, q);
        chk("state", code, q[2:0]);
    endtask : t_run

    // Every enable/ready combination, in OP
    task automatic t_enable();
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, `MTSL_ADR_CTRL, {26'h0, 3'(i), 3'h3}, q);
            cyc_wait(2);
            chk("en_a", i[0] & i[2], en_a);
            chk("en_b", i[1] & i[2], en_b);
            chk("motor_a", i[0] & i[2], m_a);
        end
        wb(1'b1, `MTSL_ADR_CTRL, 32'h0, q);
    endtask : t_enable

    // Warning and error sources: LED level, sticky status, mask, clear
    task automatic t_fault(input int s);
        logic [2:0] leds;
        wb(1'b1, `MTSL_ADR_IRQ_MASK, 32'h7, q);
        req_flt <= 3'(1 << s);
        cyc_wait(7);
        leds = {le_b, le_a, lw};
        chk("fault_led", 1 << s, leds);
        chk("irq_on", 1'b1, irq);
        wb(1'b1, `MTSL_ADR_IRQ_MASK, 32'h0, q);
        cyc_wait(2);
        chk("irq_masked", 1'b0, irq);
        req_flt <= 3'h0;
        cyc_wait(7);
        leds = {le_b, le_a, lw};
        chk("fault_led_off", 3'h0, leds);
        wb(1'b0, `MTSL_ADR_IRQ_STAT, 32'h0, q);
        chk("stat_sticky", 1 << s, q);
        wb(1'b1, `MTSL_ADR_IRQ_STAT, 32'(1 << s), q);
        wb(1'b0, `MTSL_ADR_IRQ_STAT, 32'h0, q);
        chk("stat_clear", 32'h0, q);
    endtask : t_fault

    // Echo LEDs lag their pin by the synchronizer
    task automatic t_echo(input int b);
        req_io <= 6'(1 << b);
        cyc_wait(3);
        chk("echo_early", 6'h00, {led_din, led_enc});
        cyc_wait(2);
        chk("echo", 1 << b, {led_din, led_enc});
        req_io <= 6'h00;
        cyc_wait(6);
    endtask : t_echo

    // Latch mode: one pulse per rising input, status bit set
    task automatic t_latch(input int b);
        int na, nb;
        na = 0;
        nb = 0;
        wb(1'b1, `MTSL_ADR_CTRL, 32'hC0, q);
        req_io <= 6'(16 << b);
        repeat (10) begin
            @(posedge clock);
            na += int'(lt_a === 1'b1);
            nb += int'(lt_b === 1'b1);
        end
        chk("latch_a", b == 0, na);
        chk("latch_b", b == 1, nb);
        wb(1'b0, `MTSL_ADR_IRQ_STAT, 32'h0, q);
        chk("latch_stat", 8 << b, q);
        wb(1'b1, `MTSL_ADR_IRQ_STAT, 32'h18, q);
        req_io <= 6'h00;
        cyc_wait(6);
    endtask : t_latch

    // Main sequence
    initial begin
        rst = 1'b1;
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        req_io = 6'h00;
        req_flt = 3'h0;
        cyc_wait(6);
        rst <= 1'b0;
        @(posedge clock);
        chk("run_reset", 1'b0, run);
        wb(1'b0, `MTSL_ADR_CTRL, 32'h0, q);
        chk("ctrl_reset", 32'h0, q);
        wb(1'b0, 8'h10, 32'h0, q);
        chk("unmapped", 32'h0, q);
        // Writes without the low byte lane selected must be ignored
        sel <= 4'hE;
        wb(1'b1, `MTSL_ADR_IRQ_MASK, 32'h1F, q);
        sel <= 4'hF;
        wb(1'b0, `MTSL_ADR_IRQ_MASK, 32'h0, q);
        chk("sel_gate", 32'h0, q);
        t_run(`MTSL_CODE_INIT, 0, 0);
        t_run(`MTSL_CODE_PREOP, 48, 3);
        t_run(`MTSL_CODE_SAFEOP, 16, 1);
        t_run(`MTSL_CODE_OP, FRAME, 0);
        t_run(`MTSL_CODE_BOOT, 48, 12);
        wb(1'b1, `MTSL_ADR_CTRL, 32'h5, q);
        wb(1'b0, `MTSL_ADR_CTRL, 32'h0, q);
        chk("bad_code", `MTSL_CODE_BOOT, q[2:0]);
        t_enable();
        for (int s = 0; s < 3; s++) t_fault(s);
        for (int b = 0; b < 6; b++) t_echo(b);
        for (int b = 0; b < 2; b++) t_latch(b);
        summarize();
    end
endmodule : motor_terminal_status_leds_tb

`default_nettype wire

/* tb/mtsl_pin_model.sv */
// Far-side pin model: encoder tracks, digital inputs and fault sources.
// Assumes the bench sets requested levels at rising clock edges.
`timescale 1ns/1ps
`default_nettype none

module mtsl_pin_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Requested levels: {din[1:0], enc[3:0]} and {fault_b, fault_a, warn}
    input  wire logic [5:0] req_io,
    input  wire logic [2:0] req_flt,
    // Pins towards the terminal
    output logic      [3:0] enc_o,
    output logic      [1:0] din_o,
    output logic            warn_o,
    output logic            fault_a_o,
    output logic            fault_b_o
);
    // Pins move one edge after a request, like a real field signal
    always_ff @(posedge clock) begin
        if (rst) begin
            {din_o, enc_o} <= 6'h00;
            {fault_b_o, fault_a_o, warn_o} <= 3'h0;
        end else begin
            {din_o, enc_o} <= req_io;
            {fault_b_o, fault_a_o, warn_o} <= req_flt;
        end
    end
endmodule : mtsl_pin_model

`default_nettype wire
